// *** ppfb_top.sv ***
// Port 2/3/4 pin function logic with alternate timer, interrupt and oscillator use
`timescale 1ns/10ps
`default_nettype none
module ppfb_top (
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic i_opt_osc_en,
    input wire logic i_opt_rst_as_port,
    input wire logic [3:0] i_port2_pin,
    output logic [3:0] o_port2_out,
    output logic [3:0] o_port2_oe,
    output logic [3:0] o_port2_pu,
    output logic [3:0] o_port2_pd,
    input wire logic i_port3_bidir_pin,
    output logic o_port3_bidir_out,
    output logic o_port3_bidir_oe,
    output logic o_port3_bidir_pu,
    input wire logic i_port3_input_only_pin,
    output logic o_sys_reset_n,
    input wire logic [7:0] i_port4_pin,
    output logic [7:0] o_port4_out,
    output logic [7:0] o_port4_oe,
    output logic [7:0] o_port4_pu,
    input wire logic i_timer16_output,
    input wire logic i_timer8_output,
    output logic o_timer_count_in,
    output logic o_capture_a_trig,
    output logic o_capture_b_trig,
    output logic o_osc_input,
    output logic o_osc_enable,
    output logic o_ext_irq0,
    output logic o_ext_irq1
);
    // ****************************************
    // Register state
    // ****************************************
    logic [3:0] p2_latch_r; // Port 2 output latch
    logic [3:0] p2_dir_r; // Port 2 direction, 1 = input
    logic [3:0] p2_pu_r; // Port 2 pull-up enables
    logic [3:0] p2_alt_r; // Port 2 control-mode bits
    logic p3_latch_r; // Port 3 bidir latch
    logic p3_dir_r; // Port 3 bidir direction
    logic p3_pu_r; // Port 3 bidir pull-up
    logic p3_alt_r; // Port 3 bidir control mode
    logic [7:0] p4_latch_r; // Port 4 output latch
    logic [7:0] p4_dir_r; // Port 4 direction
    logic [7:0] p4_pu_r; // Port 4 pull-ups
    logic [3:0] edge_sel_r; // Edge select for both interrupt inputs
    logic [1:0] irq_stat_r; // Sticky edge flags
    logic [1:0] irq_prev_r; // Previous sampled interrupt pin levels
    logic [7:0] rdata_r; // Read data register
    logic irq0_r; // Registered irq0 pulse
    logic irq1_r; // Registered irq1 pulse
    logic [3:0] p2_pd_r; // Reset pull-down state

    // ****************************************
    // Decode
    // ****************************************
    // Write strobe for one offset
    function automatic logic wr_hit(input logic wr, input logic [3:0] a, input logic [3:0] o);
        wr_hit = wr && (a == o);
    endfunction

    // Edge detector under the selected mode
    function automatic logic edge_hit(input logic [1:0] sel, input logic prev, input logic cur);
        case (sel)
            ppfb_pkg::EDGE_RISE: edge_hit = !prev && cur;
            ppfb_pkg::EDGE_FALL: edge_hit = prev && !cur;
            ppfb_pkg::EDGE_BOTH: edge_hit = prev != cur;
            default: edge_hit = 1'b0;
        endcase
    endfunction

    wire osc_mode = i_opt_osc_en; // Upper port 2 pins belong to oscillator
    wire [3:0] osc_mask = osc_mode ? 4'hC : 4'h0; // Pins taken by the oscillator
    wire irq0_src = i_port2_pin[ppfb_pkg::P2_CAP_BIT] & p2_alt_r[ppfb_pkg::P2_CAP_BIT];
    wire irq1_src = i_port3_bidir_pin & p3_alt_r;
    wire [1:0] irq_src = {irq1_src, irq0_src};
    wire [1:0] irq_edge;
    wire [3:0] p2_read; // Latch for outputs, pin for inputs
    wire p3_read;
    wire [7:0] p4_read;
    wire p34_port_ok = i_opt_rst_as_port;

    assign irq_edge[0] = edge_hit(edge_sel_r[1:0], irq_prev_r[0], irq_src[0]);
    assign irq_edge[1] = edge_hit(edge_sel_r[3:2], irq_prev_r[1], irq_src[1]);
    assign p2_read = (p2_dir_r & i_port2_pin) | (~p2_dir_r & p2_latch_r);
    assign p3_read = p3_dir_r ? i_port3_bidir_pin : p3_latch_r;
    assign p4_read = (p4_dir_r & i_port4_pin) | (~p4_dir_r & p4_latch_r);

    // Read multiplexer, unmapped offsets read zero
    logic [7:0] rdata_nxt;
    always_comb begin
        rdata_nxt = 8'h00;
        case (i_addr)
            ppfb_pkg::ADDR_P2_DATA: rdata_nxt = {4'h0, p2_read & ~osc_mask};
            ppfb_pkg::ADDR_P2_DIR: rdata_nxt = {4'h0, p2_dir_r};
            ppfb_pkg::ADDR_P2_PU: rdata_nxt = {4'h0, p2_pu_r};
            ppfb_pkg::ADDR_P2_ALT: rdata_nxt = {4'h0, p2_alt_r};
            // Bit 1 shows the input-only pin once the option frees it
            ppfb_pkg::ADDR_P3_DATA: rdata_nxt = {6'h00, i_port3_input_only_pin & p34_port_ok,
                                                 p3_read};
            ppfb_pkg::ADDR_P3_DIR: rdata_nxt = {7'h00, p3_dir_r};
            ppfb_pkg::ADDR_P3_PU: rdata_nxt = {7'h00, p3_pu_r};
            ppfb_pkg::ADDR_P3_ALT: rdata_nxt = {7'h00, p3_alt_r};
            ppfb_pkg::ADDR_P4_DATA: rdata_nxt = p4_read;
            ppfb_pkg::ADDR_P4_DIR: rdata_nxt = p4_dir_r;
            ppfb_pkg::ADDR_P4_PU: rdata_nxt = p4_pu_r;
            ppfb_pkg::ADDR_IRQ_EDGE: rdata_nxt = {4'h0, edge_sel_r};
            ppfb_pkg::ADDR_IRQ_STAT: rdata_nxt = {6'h00, irq_stat_r};
            default: rdata_nxt = 8'h00;
        endcase
    end

    // ****************************************
    // Port registers
    // ****************************************
    // Software writes; every pin comes up as an input
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            p2_latch_r <= 4'h0;
            p2_dir_r <= ppfb_pkg::DIR_RST[3:0];
            p2_pu_r <= 4'h0;
            p2_alt_r <= 4'h0;
            p3_latch_r <= 1'b0;
            p3_dir_r <= 1'b1;
            p3_pu_r <= 1'b0;
            p3_alt_r <= 1'b0;
            p4_latch_r <= ppfb_pkg::ZERO_RST;
            p4_dir_r <= ppfb_pkg::DIR_RST;
            p4_pu_r <= ppfb_pkg::ZERO_RST;
            edge_sel_r <= 4'h0;
        end else begin
            if (wr_hit(i_wr, i_addr, ppfb_pkg::ADDR_P2_DATA)) p2_latch_r <= i_wdata[3:0];
            if (wr_hit(i_wr, i_addr, ppfb_pkg::ADDR_P2_DIR)) p2_dir_r <= i_wdata[3:0];
            if (wr_hit(i_wr, i_addr, ppfb_pkg::ADDR_P2_PU)) p2_pu_r <= i_wdata[3:0];
            if (wr_hit(i_wr, i_addr, ppfb_pkg::ADDR_P2_ALT)) p2_alt_r <= i_wdata[3:0];
            if (wr_hit(i_wr, i_addr, ppfb_pkg::ADDR_P3_DATA)) p3_latch_r <= i_wdata[0];
            if (wr_hit(i_wr, i_addr, ppfb_pkg::ADDR_P3_DIR)) p3_dir_r <= i_wdata[0];
            if (wr_hit(i_wr, i_addr, ppfb_pkg::ADDR_P3_PU)) p3_pu_r <= i_wdata[0];
            if (wr_hit(i_wr, i_addr, ppfb_pkg::ADDR_P3_ALT)) p3_alt_r <= i_wdata[0];
            if (wr_hit(i_wr, i_addr, ppfb_pkg::ADDR_P4_DATA)) p4_latch_r <= i_wdata;
            if (wr_hit(i_wr, i_addr, ppfb_pkg::ADDR_P4_DIR)) p4_dir_r <= i_wdata;
            if (wr_hit(i_wr, i_addr, ppfb_pkg::ADDR_P4_PU)) p4_pu_r <= i_wdata;
            if (wr_hit(i_wr, i_addr, ppfb_pkg::ADDR_IRQ_EDGE)) edge_sel_r <= i_wdata[3:0];
        end
    end

    // ****************************************
    // Interrupt edges and read data
    // ****************************************
    // Edge flags: a new edge wins over a same-cycle clear
    logic [1:0] irq_stat_nxt;
    assign irq_stat_nxt = (irq_stat_r
                           & ~({2{wr_hit(i_wr, i_addr, ppfb_pkg::ADDR_IRQ_STAT)}} & i_wdata[1:0]))
                          | irq_edge;

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            irq_prev_r <= 2'h0;
            irq_stat_r <= 2'h0;
            irq0_r <= 1'b0;
            irq1_r <= 1'b0;
            rdata_r <= 8'h00;
        end else begin
            irq_prev_r <= irq_src;
            irq_stat_r <= irq_stat_nxt;
            irq0_r <= irq_edge[0];
            irq1_r <= irq_edge[1];
            rdata_r <= i_rd ? rdata_nxt : 8'h00;
        end
    end

    // Reset pull-down flag: high in reset, cleared on first edge after
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            p2_pd_r <= 4'hC;
        end else begin
            p2_pd_r <= 4'h0;
        end
    end

    // ****************************************
    // Pin drivers
    // ****************************************
    // Control mode on the two low bits picks the timer outputs
    wire [3:0] p2_alt_val = {2'h0, i_timer16_output, i_timer8_output};
    wire [3:0] p2_val = (p2_alt_r & p2_alt_val) | (~p2_alt_r & p2_latch_r);
    assign o_port2_out = p2_val & ~osc_mask;
    assign o_port2_oe = ~p2_dir_r & ~osc_mask & ~p2_pd_r;
    assign o_port2_pu = p2_pu_r & ~osc_mask & ~p2_pd_r & p2_dir_r;
    assign o_port2_pd = (!i_rstn) ? 4'hC : p2_pd_r;
    assign o_port3_bidir_out = p3_latch_r;
    assign o_port3_bidir_oe = ~p3_dir_r & ~p3_alt_r;
    assign o_port3_bidir_pu = p3_pu_r & p3_dir_r;
    assign o_sys_reset_n = p34_port_ok ? 1'b1 : i_port3_input_only_pin;
    assign o_port4_out = p4_latch_r;
    assign o_port4_oe = ~p4_dir_r;
    assign o_port4_pu = p4_pu_r & p4_dir_r;
    // Timer inputs from the two low port 2 pins in control mode
    assign o_timer_count_in = i_port2_pin[0] & p2_alt_r[0] & p2_dir_r[0];
    assign o_capture_b_trig = i_port2_pin[0] & p2_alt_r[0] & p2_dir_r[0];
    assign o_capture_a_trig = (i_port2_pin[0] & p2_alt_r[0] & p2_dir_r[0])
                              | (i_port2_pin[1] & p2_alt_r[1] & p2_dir_r[1]);
    assign o_osc_input = i_port2_pin[ppfb_pkg::P2_X1_BIT] & osc_mode;
    assign o_osc_enable = osc_mode;
    assign o_ext_irq0 = irq0_r;
    assign o_ext_irq1 = irq1_r;
    assign o_rdata = rdata_r;

    // ****************************************
    // Assertions
    // ****************************************
    sequence wr_dir4_s;
        i_wr && i_addr == ppfb_pkg::ADDR_P4_DIR;
    endsequence
    p4_dir_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        wr_dir4_s |=> o_port4_oe == ~$past(i_wdata))
        else $error("port 4 enable does not follow direction write");
    p2_dir_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (i_wr && i_addr == ppfb_pkg::ADDR_P2_DIR && !osc_mode) ##1 !osc_mode
        |-> o_port2_oe == ~$past(i_wdata[3:0]))
        else $error("port 2 enable does not follow direction write");
    p2_pu_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (p2_pu_r[0] && p2_dir_r[0]) |-> o_port2_pu[0])
        else $error("port 2 pull-up missing");
    osc_pins_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        osc_mode |-> (o_port2_oe[3:2] == 2'b00 && o_port2_out[3:2] == 2'b00))
        else $error("oscillator pins driven as port");
    t8_out_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (p2_alt_r[0] && !p2_dir_r[0]) |-> o_port2_out[0] == i_timer8_output)
        else $error("timer8 output not on pin");
    t16_out_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (p2_alt_r[1] && !p2_dir_r[1]) |-> o_port2_out[1] == i_timer16_output)
        else $error("timer16 output not on pin");
    cap_a_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (p2_alt_r[1] && p2_dir_r[1] && i_port2_pin[1]) |-> o_capture_a_trig && !o_timer_count_in
        || p2_alt_r[0])
        else $error("second pin capture trigger wrong");
    rise_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (edge_sel_r[1:0] == ppfb_pkg::EDGE_RISE && $rose(irq0_src)) |=> o_ext_irq0 ##1 !o_ext_irq0)
        else $error("irq0 rising edge missed");
    rst_pin_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        !p34_port_ok |-> o_sys_reset_n == i_port3_input_only_pin)
        else $error("reset pin not acting as reset");
    p3_dir_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (p3_dir_r && $past(p3_dir_r)) |-> !o_port3_bidir_oe)
        else $error("port 3 input driven");
    sequence rd_p4_s;
        i_rd && i_addr == ppfb_pkg::ADDR_P4_DATA;
    endsequence
    sequence irq1_fall_s;
        edge_sel_r[3:2] == ppfb_pkg::EDGE_FALL && $fell(irq1_src);
    endsequence
    sequence pulse1_s;
        o_ext_irq1 ##1 !o_ext_irq1;
    endsequence
    p4_read_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        rd_p4_s |=> o_rdata == $past((i_port4_pin & p4_dir_r) | (p4_latch_r & ~p4_dir_r)))
        else $error("port 4 read data wrong");
    irq1_fall_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        irq1_fall_s |=> pulse1_s)
        else $error("irq1 falling edge missed");
    irq0_both_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (edge_sel_r[1:0] == ppfb_pkg::EDGE_BOTH && $changed(irq0_src)) |=> o_ext_irq0)
        else $error("irq0 edge missed in both-edge mode");
    irq0_none_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        edge_sel_r[1:0] == ppfb_pkg::EDGE_NONE |=> !o_ext_irq0)
        else $error("irq0 pulse with no edge selected");
    flag_set_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        o_ext_irq0 |-> irq_stat_r[0])
        else $error("irq0 flag lost to a clear");
    pd_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        o_port2_pd[3:2] != 2'h0 |-> (o_port2_oe[3:2] == 2'h0 && o_port2_pu[3:2] == 2'h0))
        else $error("pulled-down pins driven or pulled up");
    cnt_in_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (p2_alt_r[0] && p2_dir_r[0])
        |-> (o_timer_count_in == i_port2_pin[0] && o_capture_b_trig == i_port2_pin[0]))
        else $error("count or capture input not from lowest pin");
endmodule
`default_nettype wire

// *** ppfb_pkg.sv ***
// Package with register map, field layouts and reset values of the port pin function block
package ppfb_pkg;
    // ****************************************
    // Register offsets (word index on the plain register port)
    // ****************************************
    localparam logic [3:0] ADDR_P2_DATA = 4'h0; // Port 2 output latch / pin read
    localparam logic [3:0] ADDR_P2_DIR = 4'h1; // Port 2 direction, 1 = input
    localparam logic [3:0] ADDR_P2_PU = 4'h2; // Port 2 pull-up enables
    localparam logic [3:0] ADDR_P2_ALT = 4'h3; // Port 2 control-mode select per bit
    localparam logic [3:0] ADDR_P3_DATA = 4'h4; // Port 3 latch / pin read
    localparam logic [3:0] ADDR_P3_DIR = 4'h5; // Port 3 direction, bit 0
    localparam logic [3:0] ADDR_P3_PU = 4'h6; // Port 3 pull-up, bit 0
    localparam logic [3:0] ADDR_P3_ALT = 4'h7; // Port 3 control-mode select, bit 0
    localparam logic [3:0] ADDR_P4_DATA = 4'h8; // Port 4 latch / pin read
    localparam logic [3:0] ADDR_P4_DIR = 4'h9; // Port 4 direction
    localparam logic [3:0] ADDR_P4_PU = 4'hA; // Port 4 pull-ups
    localparam logic [3:0] ADDR_IRQ_EDGE = 4'hB; // Edge select, [1:0] irq0, [3:2] irq1
    localparam logic [3:0] ADDR_IRQ_STAT = 4'hC; // Edge-detected flags, write 1 clears
    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int P2_TMR_BIT = 0; // Lowest port 2 bit: count/capture input, timer8 out
    localparam int P2_CAP_BIT = 1; // Second port 2 bit: capture input, timer16 out, irq0
    localparam int P2_X2_BIT = 2; // Oscillator output pin
    localparam int P2_X1_BIT = 3; // Oscillator input pin
    localparam logic [7:0] DIR_RST = 8'hFF; // All pins inputs after reset
    localparam logic [7:0] ZERO_RST = 8'h00; // Latches, pull-ups and modes cleared
    // ****************************************
    // Edge select encodings
    // ****************************************
    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
endpackage

// *** ppfb_board.sv ***
// Board model that resolves each pin level from device drivers and outside sources
`timescale 1ns/10ps
`default_nettype none
module ppfb_board (
    input wire logic i_ref_clk,
    input wire logic [12:0] i_dev_out, // Device output values {port4, port3, port2}
    input wire logic [12:0] i_dev_oe, // Device output enables
    input wire logic [12:0] i_dev_pu, // Device pull-ups
    input wire logic [12:0] i_dev_pd, // Device pull-downs
    input wire logic [12:0] i_ext_val, // Level driven by outside circuits
    input wire logic [12:0] i_ext_en, // Outside circuit drives the pin
    input wire logic i_rst_val, // Outside level on the reset/input pin
    input wire logic i_rst_en, // Outside source on the reset/input pin
    output logic [12:0] o_pin, // Resolved pin levels
    output logic o_rst_pin // Resolved reset/input pin level
);
    logic float_r = 1'b0; // Changing level seen on an undriven pin

    // Undriven pins never hold a stale level
    always_ff @(posedge i_ref_clk) begin
        float_r <= ~float_r;
    end

    // Device driver first, then outside source, then resistors
    always_comb begin
        for (int i = 0; i < 13; i++) begin
            o_pin[i] = i_dev_oe[i] ? i_dev_out[i] : i_ext_en[i] ? i_ext_val[i] :
                       i_dev_pu[i] ? 1'b1 : i_dev_pd[i] ? 1'b0 : float_r;
        end
    end

    // External pull-up holds the pin high when nothing drives it
    assign o_rst_pin = i_rst_en ? i_rst_val : 1'b1;
endmodule
`default_nettype wire

// *** ppfb_tb.sv ***
// Self-checking testbench of the port pin function block
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic osc_en = 1'b0;
    logic rst_port = 1'b0;
    logic t16 = 1'b0;
    logic t8 = 1'b0;
    logic [12:0] x_val = 13'h0000; // Outside levels {port4, port3, port2}
    logic [12:0] x_en = 13'h0000;
    logic rs_val = 1'b1;
    logic rs_en = 1'b0;
    wire [12:0] pin, d_out, d_oe, d_pu;
    logic [3:0] p2_pd;
    logic [7:0] rdata;
    logic rs_pin, sys_rstn, cnt_in, cap_a, cap_b, osc_in, osc_on, irq0, irq1;
    int n_fail = 0;
    int num_checks = 0;

    always #25 clk = ~clk;

    ppfb_top u_ppfb_top (.i_ref_clk(clk), .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_opt_osc_en(osc_en),
        .i_opt_rst_as_port(rst_port), .i_port2_pin(pin[3:0]), .o_port2_out(d_out[3:0]),
        .o_port2_oe(d_oe[3:0]), .o_port2_pu(d_pu[3:0]), .o_port2_pd(p2_pd),
        .i_port3_bidir_pin(pin[4]), .o_port3_bidir_out(d_out[4]), .o_port3_bidir_oe(d_oe[4]),
        .o_port3_bidir_pu(d_pu[4]), .i_port3_input_only_pin(rs_pin), .o_sys_reset_n(sys_rstn),
        .i_port4_pin(pin[12:5]), .o_port4_out(d_out[12:5]), .o_port4_oe(d_oe[12:5]),
        .o_port4_pu(d_pu[12:5]), .i_timer16_output(t16), .i_timer8_output(t8),
        .o_timer_count_in(cnt_in), .o_capture_a_trig(cap_a), .o_capture_b_trig(cap_b),
        .o_osc_input(osc_in), .o_osc_enable(osc_on), .o_ext_irq0(irq0), .o_ext_irq1(irq1));

    ppfb_board u_ppfb_board (.i_ref_clk(clk), .i_dev_out(d_out), .i_dev_oe(d_oe),
        .i_dev_pu(d_pu), .i_dev_pd({9'h000, p2_pd}), .i_ext_val(x_val), .i_ext_en(x_en),
        .i_rst_val(rs_val), .i_rst_en(rs_en), .o_pin(pin), .o_rst_pin(rs_pin));

    // Verdict and end of run
    task automatic conclude();
        $display("checks=%0d errors=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Compare one value
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            n_fail++;
        end
    endtask

    // Let n edges pass, then settle
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // One-cycle register write
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask

    // One-cycle read, data taken in the following cycle
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask

    // Rising then falling edge on an interrupt pin, pulses counted per edge
    task automatic irq_case(input int k, input logic [1:0] mode);
        int cnt;
        int bitn;
        logic exp;
        bitn = (k == 0) ? 1 : 4;
        @(posedge clk);
        x_val[bitn] <= 1'b0;
        cyc(3);
        wr_reg(ppfb_pkg::ADDR_IRQ_EDGE, 8'(mode) << (2 * k));
        for (int e = 0; e < 2; e++) begin
            cnt = 0;
            exp = (mode == ppfb_pkg::EDGE_BOTH) ||
                  (mode == ((e == 0) ? ppfb_pkg::EDGE_RISE : ppfb_pkg::EDGE_FALL));
            @(posedge clk);
            x_val[bitn] <= (e == 0);
            repeat (4) begin
                @(posedge clk);
                #1;
                if (((k == 0) ? irq0 : irq1) === 1'b1) begin
                    cnt++;
                end
            end
            chk(8'(cnt), {7'h00, exp});
        end
    endtask

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        conclude();
    end

    // Main sequence
    initial begin
        repeat (19) @(posedge clk);
        #1;
        chk({4'h0, p2_pd}, 8'h0C);
        chk(d_oe[12:5], 8'h00);
        chk({3'h0, d_oe[4:0]}, 8'h00);
        @(posedge clk);
        rstn <= 1'b1;
        x_en <= 13'h1FFF;
        cyc(1);
        chk({4'h0, p2_pd}, 8'h00);
        rd_chk(ppfb_pkg::ADDR_P2_DIR, 8'h0F);
        rd_chk(ppfb_pkg::ADDR_P3_DIR, 8'h01);
        rd_chk(ppfb_pkg::ADDR_P4_DIR, 8'hFF);
        // Port 4 with mixed directions
        wr_reg(ppfb_pkg::ADDR_P4_DIR, 8'h0F);
        wr_reg(ppfb_pkg::ADDR_P4_DATA, 8'hA5);
        wr_reg(ppfb_pkg::ADDR_P4_PU, 8'hFF);
        x_val[12:5] <= 8'h3C;
        rd_chk(ppfb_pkg::ADDR_P4_DATA, 8'hAC);
        chk(d_oe[12:5], 8'hF0);
        chk(d_pu[12:5], 8'h0F);
        chk(d_out[12:5] & 8'hF0, 8'hA0);
        // Port 2 in port mode, low bits outputs
        wr_reg(ppfb_pkg::ADDR_P2_DIR, 8'h0C);
        wr_reg(ppfb_pkg::ADDR_P2_DATA, 8'h06);
        wr_reg(ppfb_pkg::ADDR_P2_PU, 8'h0F);
        chk({4'h0, d_oe[3:0]}, 8'h03);
        chk({4'h0, d_pu[3:0]}, 8'h0C);
        chk({6'h00, d_out[1:0]}, 8'h02);
        // Timer outputs in control mode, then one bit back to port
        wr_reg(ppfb_pkg::ADDR_P2_ALT, 8'h03);
        t8 <= 1'b1;
        cyc(1);
        chk({6'h00, d_out[1:0]}, 8'h01);
        wr_reg(ppfb_pkg::ADDR_P2_ALT, 8'h01);
        chk({6'h00, d_out[1:0]}, 8'h03);
        // Timer inputs in control mode
        wr_reg(ppfb_pkg::ADDR_P2_ALT, 8'h03);
        wr_reg(ppfb_pkg::ADDR_P2_DIR, 8'h0F);
        x_val[1:0] <= 2'b01;
        cyc(2);
        chk({5'h00, cnt_in, cap_a, cap_b}, 8'h07);
        x_val[1:0] <= 2'b10;
        cyc(2);
        chk({5'h00, cnt_in, cap_a, cap_b}, 8'h02);
        // Every edge mode on both interrupt inputs
        wr_reg(ppfb_pkg::ADDR_P3_ALT, 8'h01);
        for (int k = 0; k < 2; k++) begin
            for (int m = 0; m < 4; m++) begin
                irq_case(k, 2'(m));
            end
        end
        // Edge select read back, sticky flags, write-one clear
        rd_chk(ppfb_pkg::ADDR_IRQ_EDGE, 8'h0C);
        rd_chk(ppfb_pkg::ADDR_IRQ_STAT, 8'h03);
        wr_reg(ppfb_pkg::ADDR_IRQ_STAT, 8'h03);
        rd_chk(ppfb_pkg::ADDR_IRQ_STAT, 8'h00);
        // Port 3 bidirectional bit in port mode
        wr_reg(ppfb_pkg::ADDR_P3_ALT, 8'h00);
        wr_reg(ppfb_pkg::ADDR_P3_DIR, 8'h00);
        wr_reg(ppfb_pkg::ADDR_P3_DATA, 8'h01);
        wr_reg(ppfb_pkg::ADDR_P3_PU, 8'h01);
        chk({5'h00, d_oe[4], d_out[4], d_pu[4]}, 8'h06);
        wr_reg(ppfb_pkg::ADDR_P3_DIR, 8'h01);
        chk({6'h00, d_oe[4], d_pu[4]}, 8'h01);
        // Shared reset pin: reset first, general input once freed
        x_val[4] <= 1'b1;
        rs_en <= 1'b1;
        rs_val <= 1'b0;
        cyc(2);
        chk({7'h00, sys_rstn}, 8'h00);
        rst_port <= 1'b1;
        cyc(2);
        chk({7'h00, sys_rstn}, 8'h01);
        rd_chk(ppfb_pkg::ADDR_P3_DATA, 8'h01);
        rs_val <= 1'b1;
        rd_chk(ppfb_pkg::ADDR_P3_DATA, 8'h03);
        // Oscillator use chosen by the option input
        osc_en <= 1'b1;
        x_val[3] <= 1'b1;
        cyc(2);
        chk({6'h00, osc_on, osc_in}, 8'h03);
        // Oscillator pins stay undriven even as port outputs
        wr_reg(ppfb_pkg::ADDR_P2_DATA, 8'h0F);
        wr_reg(ppfb_pkg::ADDR_P2_DIR, 8'h00);
        chk({4'h0, d_oe[3:0]}, 8'h03);
        chk({4'h0, d_out[3:0]}, 8'h01);
        rd_chk(ppfb_pkg::ADDR_P2_DATA, 8'h03);
        // Unmapped index reads zero and ignores writes
        wr_reg(4'hD, 8'hFF);
        rd_chk(4'hD, 8'h00);
        rd_chk(4'hF, 8'h00);
        // Second reset in mid-run restores pull-downs and inputs
        rstn <= 1'b0;
        cyc(1);
        chk({4'h0, p2_pd}, 8'h0C);
        chk({3'h0, d_oe[4:0]}, 8'h00);
        @(posedge clk);
        rstn <= 1'b1;
        cyc(1);
        chk({4'h0, p2_pd}, 8'h00);
        rd_chk(ppfb_pkg::ADDR_P2_DIR, 8'h0F);
        rd_chk(ppfb_pkg::ADDR_P2_ALT, 8'h00);
        conclude();
    end
endmodule
`default_nettype wire
